// ### hw/ehsp_pkg.sv
// Constants shared by the external host slave port
package ehsp_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int BUS_AW = 32;
    localparam int REG_AW = 3;
    localparam int BYTE_AW = 17;
    // Address bus bit positions
    localparam int REG_SEL_BIT = 16;
    localparam int DACK_BIT = 15;
    localparam int DRQO_BIT = 14;
    localparam int DRQI_BIT = 13;
    // Control bit reset values, before the straps are taken
    localparam logic ACK_POL_RST = 1'b1;
    localparam logic ACK_DRIVE_RST = 1'b0;
    localparam logic IRQ_DIR_N_RST = 1'b1;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### hw/ehsp_rise.sv
// Rising-edge detector for a pin sampled on the system clock
`timescale 1ns/10ps
module ehsp_rise (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic rise
);
    logic last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 1'b0;
        end else begin
            last <= level;
        end
    end

    assign rise = level && !last;
endmodule

// ### hw/ehsp_port.sv
// External host slave port: cycle control, DMA routing, interrupts, transceiver
// Behaviour
// - Chip select low starts a decoded cycle; acknowledge ends it; host then releases select.
// - DMA cycles invert direction: high writes into FIFO, low reads from it.
// - Seventeen-bit address; top bit low is shared RAM, high is port register.
// - DMA cycles ignore the address bus except acknowledge bit; only FIFO data.
// - DMA enable low turns on DMA; address bit 15 becomes active-low acknowledge.
// - DMA on, alternate route 0: bits 14 and 13 drive active-low requests.
// - Alternate route 1: ORed active-high requests on second irq pin; bits readdress.
// - Outbound request active only when outbound FIFO not empty and enabled.
// - Inbound request active only when inbound FIFO not full and enabled.
// - Sixteen-bit or eight-bit data mode; low lines become inputs in eight-bit.
// - Acknowledge polarity selectable, reset value from strap A1.
// - Acknowledge totem-pole or open-drain, reset value from strap A6.
// - Interrupt pending from status flag, data flag or enabled FIFO condition.
// - Pending interrupt driven low only when globally enabled; pin select chooses pin.
// - Irq direction bit 0 makes second irq pin an input, except with DMA on and alternate route 1; strap A5 reset.
// - Rising edge on second irq input sets external flag and local interrupt.
// - Transceiver direction high for device-to-host data, low otherwise.
// - Transceiver enable low while a transfer is in progress.
// - Option: transceiver direction pin becomes clock input timing the acknowledge.
// - Shared RAM access requests internal bus, translates address, completes with data.
// - Physical address is external address, doubled in sixteen-bit mode, plus programmed base offset.
// - After chip select returns high, transceiver enable is released.
`timescale 1ns/10ps
module ehsp_port
    import ehsp_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PORT_CHIP_SELECT_N,
    input wire logic PORT_DIRECTION,
    input wire logic [ehsp_pkg::ADDR_W-1:0] PORT_ADDRESS_BUS,
    output logic [1:0] DMA_REQUEST_PIN_O,
    output logic [1:0] DMA_REQUEST_PIN_OE,
    input wire logic [ehsp_pkg::DATA_W-1:0] PORT_DATA_BUS_I,
    output logic [ehsp_pkg::DATA_W-1:0] PORT_DATA_BUS_O,
    output logic [1:0] PORT_DATA_BUS_OE,
    output logic CYCLE_ACKNOWLEDGE_O,
    output logic CYCLE_ACKNOWLEDGE_OE,
    output logic HOST_IRQ_FIRST_N,
    input wire logic HOST_IRQ_SECOND_I,
    output logic HOST_IRQ_SECOND_O,
    output logic HOST_IRQ_SECOND_OE,
    input wire logic TRANSCEIVER_DIRECTION_I,
    output logic TRANSCEIVER_DIRECTION_O,
    output logic TRANSCEIVER_DIRECTION_OE,
    output logic TRANSCEIVER_ENABLE_N,
    input wire logic DMA_ENABLE_N,
    input wire logic ALTERNATE_REQUEST_ROUTE,
    input wire logic OUTBOUND_READY_ENABLE,
    input wire logic INBOUND_ROOM_ENABLE,
    input wire logic WIDE_MODE,
    input wire logic ACK_SYNC_MODE,
    input wire logic STRAP_A1,
    input wire logic STRAP_A5,
    input wire logic STRAP_A6,
    input wire logic CTRL_WRITE,
    input wire logic CTRL_ACK_POLARITY,
    input wire logic CTRL_ACK_DRIVE,
    input wire logic CTRL_IRQ_DIRECTION_N,
    output logic ACK_POLARITY_SELECT,
    output logic ACK_DRIVE_TYPE,
    output logic IRQ_PIN_DIRECTION_N,
    input wire logic STATUS_IRQ_FLAG,
    input wire logic DATA_AVAIL_IRQ_FLAG,
    input wire logic FIFO_IRQ_CONDITION,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic IRQ_PIN_SELECT,
    input wire logic EXTERNAL_IRQ_CLEAR,
    output logic EXTERNAL_IRQ_FLAG,
    output logic LOCAL_IRQ,
    output logic [7:0] GENERAL_INPUTS,
    input wire logic OUTBOUND_FIFO_EMPTY,
    input wire logic INBOUND_FIFO_FULL,
    output logic FIFO_READ,
    input wire logic [ehsp_pkg::DATA_W-1:0] FIFO_READ_DATA,
    output logic FIFO_WRITE,
    output logic [ehsp_pkg::DATA_W-1:0] FIFO_WRITE_DATA,
    output logic REG_READ,
    output logic REG_WRITE,
    output logic [ehsp_pkg::REG_AW-1:0] REG_INDEX,
    output logic [ehsp_pkg::DATA_W-1:0] REG_WRITE_DATA,
    input wire logic [ehsp_pkg::DATA_W-1:0] REG_READ_DATA,
    input wire logic [ehsp_pkg::BUS_AW-1:0] SHARED_BASE,
    output logic BUS_REQUEST,
    input wire logic BUS_GRANT,
    output logic [ehsp_pkg::BUS_AW-1:0] BUS_ADDRESS,
    output logic BUS_WRITE,
    output logic BUS_BYTE_MODE,
    output logic [ehsp_pkg::DATA_W-1:0] BUS_WRITE_DATA,
    input wire logic [ehsp_pkg::DATA_W-1:0] BUS_READ_DATA,
    input wire logic BUS_DONE
);
    import ehsp_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_BUS_REQ, ST_BUS_XFER, ST_SYNC, ST_ACK} ehsp_state_t;

    ehsp_state_t state;
    ehsp_state_t next_state;
    logic strap_done;
    logic rd_dir;
    logic [DATA_W-1:0] read_data;
    logic [DATA_W-1:0] write_data;
    logic [BYTE_AW-1:0] byte_offset;
    logic dma_on;
    logic cs_go;
    logic dma_go;
    logic cycle_read;
    logic [DATA_W-1:0] in_word;
    logic [BYTE_AW-1:0] next_offset;
    logic out_req;
    logic in_req;
    logic irq_pending;
    logic irq_drive;
    logic sync_rise;
    logic ext_rise;
    logic ack_active;

    assign dma_on = !DMA_ENABLE_N;
    assign cs_go = !PORT_CHIP_SELECT_N;
    // Chip select must stay high in DMA, so a low select is never a DMA cycle
    assign dma_go = dma_on && !PORT_ADDRESS_BUS[DACK_BIT] && PORT_CHIP_SELECT_N;
    // Read from the host's view: direction sense flips in DMA
    assign cycle_read = cs_go ? PORT_DIRECTION : !PORT_DIRECTION;
    // Eight-bit mode carries data on the upper lines only
    assign in_word = WIDE_MODE ? PORT_DATA_BUS_I : {BYTE_ZERO, PORT_DATA_BUS_I[15:8]};

    // Lines taken by DMA control cannot address shared RAM
    always_comb begin
        next_offset = WIDE_MODE ? {PORT_ADDRESS_BUS[15:0], 1'b0}
                                : {1'b0, PORT_ADDRESS_BUS[15:0]};
        if (dma_on) begin
            next_offset[DACK_BIT + (WIDE_MODE ? 1 : 0)] = 1'b0;
            if (!ALTERNATE_REQUEST_ROUTE) begin
                next_offset[DRQO_BIT + (WIDE_MODE ? 1 : 0)] = 1'b0;
                next_offset[DRQI_BIT + (WIDE_MODE ? 1 : 0)] = 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cs_go && !PORT_ADDRESS_BUS[REG_SEL_BIT]) begin
                    next_state = ST_BUS_REQ;
                end else if (cs_go || dma_go) begin
                    next_state = ST_SYNC;
                end
            end
            ST_BUS_REQ: begin
                if (BUS_GRANT) begin
                    next_state = ST_BUS_XFER;
                end
            end
            ST_BUS_XFER: begin
                if (BUS_DONE) begin
                    next_state = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (!ACK_SYNC_MODE || sync_rise) begin
                    next_state = ST_ACK;
                end
            end
            ST_ACK: begin
                // Wait for both select and DMA acknowledge to release
                if (PORT_CHIP_SELECT_N && !dma_go) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycle attributes are frozen at the start of each cycle
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rd_dir <= 1'b0;
            write_data <= DATA_RST;
            byte_offset <= '0;
        end else if (state == ST_IDLE && (cs_go || dma_go)) begin
            rd_dir <= cycle_read;
            write_data <= in_word;
            byte_offset <= next_offset;
        end
    end

    // Register and FIFO reads answer in the start cycle; RAM on bus completion
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            read_data <= DATA_RST;
        end else if (REG_READ) begin
            read_data <= REG_READ_DATA;
        end else if (FIFO_READ) begin
            read_data <= FIFO_READ_DATA;
        end else if (state == ST_BUS_XFER && BUS_DONE && rd_dir) begin
            read_data <= BUS_READ_DATA;
        end
    end

    assign REG_INDEX = PORT_ADDRESS_BUS[REG_AW-1:0];
    assign REG_WRITE_DATA = in_word;
    assign REG_READ = state == ST_IDLE && cs_go && PORT_ADDRESS_BUS[REG_SEL_BIT] && cycle_read;
    assign REG_WRITE = state == ST_IDLE && cs_go && PORT_ADDRESS_BUS[REG_SEL_BIT] && !cycle_read;
    assign FIFO_READ = state == ST_IDLE && dma_go && cycle_read;
    assign FIFO_WRITE = state == ST_IDLE && dma_go && !cycle_read;
    assign FIFO_WRITE_DATA = in_word;

    assign BUS_REQUEST = state == ST_BUS_REQ || state == ST_BUS_XFER;
    assign BUS_ADDRESS = SHARED_BASE + {{(BUS_AW - BYTE_AW){1'b0}}, byte_offset};
    assign BUS_WRITE = !rd_dir;
    assign BUS_BYTE_MODE = !WIDE_MODE;
    assign BUS_WRITE_DATA = write_data;

    // Straps are caught on the first edge after reset release
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            strap_done <= 1'b0;
            ACK_POLARITY_SELECT <= ACK_POL_RST;
            ACK_DRIVE_TYPE <= ACK_DRIVE_RST;
            IRQ_PIN_DIRECTION_N <= IRQ_DIR_N_RST;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            ACK_POLARITY_SELECT <= STRAP_A1;
            ACK_DRIVE_TYPE <= STRAP_A6;
            IRQ_PIN_DIRECTION_N <= STRAP_A5;
        end else if (CTRL_WRITE) begin
            ACK_POLARITY_SELECT <= CTRL_ACK_POLARITY;
            ACK_DRIVE_TYPE <= CTRL_ACK_DRIVE;
            IRQ_PIN_DIRECTION_N <= CTRL_IRQ_DIRECTION_N;
        end
    end

    // Polarity 1 is active-low acknowledge, 0 active-high ready
    assign ack_active = state == ST_ACK;
    always_comb begin
        if (ACK_DRIVE_TYPE) begin
            // Open drain only pulls low; the pull-up gives the high level
            CYCLE_ACKNOWLEDGE_O = 1'b0;
            CYCLE_ACKNOWLEDGE_OE = ack_active ? ACK_POLARITY_SELECT : !ACK_POLARITY_SELECT;
        end else begin
            CYCLE_ACKNOWLEDGE_O = ack_active ? !ACK_POLARITY_SELECT : ACK_POLARITY_SELECT;
            CYCLE_ACKNOWLEDGE_OE = 1'b1;
        end
    end

    assign PORT_DATA_BUS_O = WIDE_MODE ? read_data : {read_data[7:0], BYTE_ZERO};
    assign PORT_DATA_BUS_OE = {ack_active && rd_dir, ack_active && rd_dir && WIDE_MODE};

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            GENERAL_INPUTS <= BYTE_ZERO;
        end else if (!WIDE_MODE) begin
            GENERAL_INPUTS <= PORT_DATA_BUS_I[7:0];
        end
    end

    assign TRANSCEIVER_ENABLE_N = state == ST_IDLE;
    assign TRANSCEIVER_DIRECTION_O = rd_dir;
    assign TRANSCEIVER_DIRECTION_OE = !ACK_SYNC_MODE;

    ehsp_rise u_sync_clk (
        .clk(MCLK),
        .rst_n(NRST),
        .level(TRANSCEIVER_DIRECTION_I && ACK_SYNC_MODE),
        .rise(sync_rise)
    );

    assign out_req = !OUTBOUND_FIFO_EMPTY && OUTBOUND_READY_ENABLE;
    assign in_req = !INBOUND_FIFO_FULL && INBOUND_ROOM_ENABLE;
    assign DMA_REQUEST_PIN_OE = {2{dma_on && !ALTERNATE_REQUEST_ROUTE}};
    assign DMA_REQUEST_PIN_O = {!out_req, !in_req};

    assign irq_pending = STATUS_IRQ_FLAG || DATA_AVAIL_IRQ_FLAG || FIFO_IRQ_CONDITION;
    assign irq_drive = irq_pending && GLOBAL_IRQ_ENABLE;
    assign HOST_IRQ_FIRST_N = !(irq_drive && !IRQ_PIN_SELECT);

    always_comb begin
        if (dma_on && ALTERNATE_REQUEST_ROUTE) begin
            HOST_IRQ_SECOND_O = out_req || in_req;
            HOST_IRQ_SECOND_OE = 1'b1;
        end else if (!IRQ_PIN_DIRECTION_N) begin
            HOST_IRQ_SECOND_O = 1'b1;
            HOST_IRQ_SECOND_OE = 1'b0;
        end else begin
            HOST_IRQ_SECOND_O = !(irq_drive && IRQ_PIN_SELECT);
            HOST_IRQ_SECOND_OE = 1'b1;
        end
    end

    ehsp_rise u_ext_irq (
        .clk(MCLK),
        .rst_n(NRST),
        .level(HOST_IRQ_SECOND_I),
        .rise(ext_rise)
    );

    // A new edge in the clearing cycle wins over the clear
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            EXTERNAL_IRQ_FLAG <= 1'b0;
        end else if (ext_rise && !HOST_IRQ_SECOND_OE) begin
            EXTERNAL_IRQ_FLAG <= 1'b1;
        end else if (EXTERNAL_IRQ_CLEAR) begin
            EXTERNAL_IRQ_FLAG <= 1'b0;
        end
    end

    assign LOCAL_IRQ = EXTERNAL_IRQ_FLAG;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence s_ram_start;
        state == ST_IDLE && cs_go && !PORT_ADDRESS_BUS[REG_SEL_BIT];
    endsequence

    sequence s_granted;
        BUS_REQUEST && BUS_GRANT;
    endsequence

    chk_ram_bus_request: assert property (s_ram_start |=> BUS_REQUEST)
        else $error("shared RAM cycle did not request the bus");
    chk_grant_to_done: assert property (s_granted ##1 (BUS_DONE && rd_dir) |=>
        state == ST_SYNC && read_data == $past(BUS_READ_DATA))
        else $error("bus read data not captured on completion");
    chk_ack_until_cs: assert property (ack_active && !PORT_CHIP_SELECT_N |=> ack_active)
        else $error("acknowledge dropped before select release");
    chk_pen_release: assert property (ack_active && PORT_CHIP_SELECT_N && !dma_go
        |=> TRANSCEIVER_ENABLE_N)
        else $error("transceiver enable not released after select");
    chk_enable_in_cycle: assert property (state != ST_IDLE |-> !TRANSCEIVER_ENABLE_N)
        else $error("transceiver enable high during transfer");
    chk_outbound_req: assert property (DMA_REQUEST_PIN_OE[1] && !DMA_REQUEST_PIN_O[1]
        |-> !OUTBOUND_FIFO_EMPTY && OUTBOUND_READY_ENABLE)
        else $error("outbound request without data or enable");
    chk_inbound_req: assert property (DMA_REQUEST_PIN_OE[0] && !DMA_REQUEST_PIN_O[0]
        |-> !INBOUND_FIFO_FULL && INBOUND_ROOM_ENABLE)
        else $error("inbound request without room or enable");
    chk_alt_route: assert property (dma_on && ALTERNATE_REQUEST_ROUTE |->
        DMA_REQUEST_PIN_OE == 2'b00 && HOST_IRQ_SECOND_O == (out_req || in_req))
        else $error("alternate request routing wrong");
    chk_irq_first: assert property (!HOST_IRQ_FIRST_N |->
        irq_pending && GLOBAL_IRQ_ENABLE && !IRQ_PIN_SELECT)
        else $error("first irq pin driven without qualification");
    chk_ext_flag_set: assert property ($rose(HOST_IRQ_SECOND_I) && !HOST_IRQ_SECOND_OE
        && !$past(HOST_IRQ_SECOND_OE) |=> EXTERNAL_IRQ_FLAG [*1])
        else $error("external irq edge did not set flag");
    chk_dma_no_regs: assert property (dma_go |-> !REG_READ && !REG_WRITE && !BUS_REQUEST)
        else $error("DMA cycle touched registers or RAM");
    chk_dir_read: assert property (ack_active && !ACK_SYNC_MODE |->
        TRANSCEIVER_DIRECTION_O == rd_dir && PORT_DATA_BUS_OE[1] == rd_dir)
        else $error("transceiver direction mismatch");
endmodule

// ### bench/ehsp_host_model.sv
// Behavioural external processor running select and DMA cycles
`timescale 1ns/10ps
module ehsp_host_model
    import ehsp_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic go_dma,
    input wire logic go_rd,
    input wire logic [ehsp_pkg::ADDR_W-1:0] go_addr,
    input wire logic [ehsp_pkg::DATA_W-1:0] go_data,
    input wire logic ack_o,
    input wire logic ack_oe,
    input wire logic ack_pol,
    input wire logic ack_od,
    input wire logic [ehsp_pkg::DATA_W-1:0] data_o,
    output logic cs_n,
    output logic dir,
    output logic [ehsp_pkg::ADDR_W-1:0] addr,
    output logic [ehsp_pkg::DATA_W-1:0] data_i,
    output logic acked,
    output logic done,
    output logic [ehsp_pkg::DATA_W-1:0] rdata
);
    // Open drain floats high through the pull-up
    assign acked = (ack_od ? !ack_oe : ack_o) != ack_pol;
    initial begin
        cs_n = 1'b1;
        dir = 1'b0;
        addr = 17'h18000;
        data_i = DATA_RST;
        done = 1'b0;
        rdata = DATA_RST;
        forever begin
            @(posedge clk);
            done <= 1'b0;
            if (go) begin
                dir <= go_dma ? !go_rd : go_rd;
                addr <= go_dma ? {go_addr[16], 1'b0, go_addr[14:0]} : go_addr;
                data_i <= go_data;
                cs_n <= go_dma;
                @(posedge clk);
                // A hang is left to the bench timeout
                while (acked !== 1'b1) begin
                    @(posedge clk);
                end
                rdata <= data_o;
                done <= 1'b1;
                cs_n <= 1'b1;
                addr[15] <= 1'b1;
                // Released bus shows a changed pattern, not the last word
                data_i <= ~go_data;
            end
        end
    end
endmodule

// ### bench/test_external_host_slave_port.sv
// Self-checking bench for the external host slave port
`timescale 1ns/10ps
module test_external_host_slave_port;
    import ehsp_pkg::*;
    logic MCLK, NRST, CTRL_WRITE, CTRL_ACK_POLARITY, CTRL_ACK_DRIVE, CTRL_IRQ_DIRECTION_N;
    logic DMA_ENABLE_N, ALTERNATE_REQUEST_ROUTE, OUTBOUND_READY_ENABLE, INBOUND_ROOM_ENABLE;
    logic WIDE_MODE, ACK_SYNC_MODE, STRAP_A1, STRAP_A5, STRAP_A6, EXTERNAL_IRQ_CLEAR;
    logic STATUS_IRQ_FLAG, DATA_AVAIL_IRQ_FLAG, FIFO_IRQ_CONDITION, GLOBAL_IRQ_ENABLE;
    logic IRQ_PIN_SELECT, OUTBOUND_FIFO_EMPTY, INBOUND_FIFO_FULL, BUS_GRANT, BUS_DONE;
    logic PORT_CHIP_SELECT_N, PORT_DIRECTION, HOST_IRQ_SECOND_I, TRANSCEIVER_DIRECTION_I;
    logic CYCLE_ACKNOWLEDGE_O, CYCLE_ACKNOWLEDGE_OE, HOST_IRQ_FIRST_N, HOST_IRQ_SECOND_O;
    logic HOST_IRQ_SECOND_OE, TRANSCEIVER_DIRECTION_O, TRANSCEIVER_DIRECTION_OE;
    logic TRANSCEIVER_ENABLE_N, ACK_POLARITY_SELECT, ACK_DRIVE_TYPE, IRQ_PIN_DIRECTION_N;
    logic EXTERNAL_IRQ_FLAG, LOCAL_IRQ, FIFO_READ, FIFO_WRITE, REG_READ, REG_WRITE, ro, ri;
    logic BUS_REQUEST, BUS_WRITE, BUS_BYTE_MODE, go, go_dma, go_rd, acked, done, irq2_drv;
    logic [1:0] DMA_REQUEST_PIN_O, DMA_REQUEST_PIN_OE, PORT_DATA_BUS_OE;
    logic [7:0] GENERAL_INPUTS;
    logic [ehsp_pkg::REG_AW-1:0] REG_INDEX;
    logic [ehsp_pkg::ADDR_W-1:0] PORT_ADDRESS_BUS, host_addr, go_addr;
    logic [ehsp_pkg::DATA_W-1:0] PORT_DATA_BUS_I, PORT_DATA_BUS_O, FIFO_READ_DATA;
    logic [ehsp_pkg::DATA_W-1:0] FIFO_WRITE_DATA, REG_WRITE_DATA, REG_READ_DATA;
    logic [ehsp_pkg::DATA_W-1:0] BUS_WRITE_DATA, BUS_READ_DATA, host_data, go_data, rdata;
    logic [ehsp_pkg::BUS_AW-1:0] SHARED_BASE, BUS_ADDRESS;
    logic [33:0] e2;
    logic [31:0] rnd, e;
    logic [31:0] rd_q[$];
    logic [33:0] bus_q[$];
    int num_errors, check_count, cycles, pulses;

    // Shared pins resolve from whoever drives them
    assign PORT_ADDRESS_BUS = {host_addr[16:15],
        DMA_REQUEST_PIN_OE[1] ? DMA_REQUEST_PIN_O[1] : host_addr[14],
        DMA_REQUEST_PIN_OE[0] ? DMA_REQUEST_PIN_O[0] : host_addr[13], host_addr[12:0]};
    assign PORT_DATA_BUS_I[15:8] = PORT_DATA_BUS_OE[1] ? PORT_DATA_BUS_O[15:8] : host_data[15:8];
    assign PORT_DATA_BUS_I[7:0] = PORT_DATA_BUS_OE[0] ? PORT_DATA_BUS_O[7:0] : host_data[7:0];
    assign HOST_IRQ_SECOND_I = HOST_IRQ_SECOND_OE ? HOST_IRQ_SECOND_O : irq2_drv;
    assign TRANSCEIVER_DIRECTION_I = TRANSCEIVER_DIRECTION_OE ? TRANSCEIVER_DIRECTION_O : cycles[2];

    ehsp_port ehsp_port_inst (.MCLK, .NRST, .PORT_CHIP_SELECT_N, .PORT_DIRECTION,
        .PORT_ADDRESS_BUS, .DMA_REQUEST_PIN_O, .DMA_REQUEST_PIN_OE, .PORT_DATA_BUS_I,
        .PORT_DATA_BUS_O, .PORT_DATA_BUS_OE, .CYCLE_ACKNOWLEDGE_O, .CYCLE_ACKNOWLEDGE_OE,
        .HOST_IRQ_FIRST_N, .HOST_IRQ_SECOND_I, .HOST_IRQ_SECOND_O, .HOST_IRQ_SECOND_OE,
        .TRANSCEIVER_DIRECTION_I, .TRANSCEIVER_DIRECTION_O, .TRANSCEIVER_DIRECTION_OE,
        .TRANSCEIVER_ENABLE_N, .DMA_ENABLE_N, .ALTERNATE_REQUEST_ROUTE, .OUTBOUND_READY_ENABLE,
        .INBOUND_ROOM_ENABLE, .WIDE_MODE, .ACK_SYNC_MODE, .STRAP_A1, .STRAP_A5, .STRAP_A6,
        .CTRL_WRITE, .CTRL_ACK_POLARITY, .CTRL_ACK_DRIVE, .CTRL_IRQ_DIRECTION_N,
        .ACK_POLARITY_SELECT, .ACK_DRIVE_TYPE, .IRQ_PIN_DIRECTION_N, .STATUS_IRQ_FLAG,
        .DATA_AVAIL_IRQ_FLAG, .FIFO_IRQ_CONDITION, .GLOBAL_IRQ_ENABLE, .IRQ_PIN_SELECT,
        .EXTERNAL_IRQ_CLEAR, .EXTERNAL_IRQ_FLAG, .LOCAL_IRQ, .GENERAL_INPUTS,
        .OUTBOUND_FIFO_EMPTY, .INBOUND_FIFO_FULL, .FIFO_READ, .FIFO_READ_DATA, .FIFO_WRITE,
        .FIFO_WRITE_DATA, .REG_READ, .REG_WRITE, .REG_INDEX, .REG_WRITE_DATA, .REG_READ_DATA,
        .SHARED_BASE, .BUS_REQUEST, .BUS_GRANT, .BUS_ADDRESS, .BUS_WRITE, .BUS_BYTE_MODE,
        .BUS_WRITE_DATA, .BUS_READ_DATA, .BUS_DONE);

    ehsp_host_model ehsp_host_model_inst (.clk(MCLK), .go(go), .go_dma(go_dma), .go_rd(go_rd),
        .go_addr(go_addr), .go_data(go_data), .ack_o(CYCLE_ACKNOWLEDGE_O),
        .ack_oe(CYCLE_ACKNOWLEDGE_OE), .ack_pol(ACK_POLARITY_SELECT), .ack_od(ACK_DRIVE_TYPE),
        .data_o(PORT_DATA_BUS_O), .cs_n(PORT_CHIP_SELECT_N), .dir(PORT_DIRECTION),
        .addr(host_addr), .data_i(host_data), .acked(acked), .done(done), .rdata(rdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic host_cycle(input logic dma, input logic rd, input logic [16:0] a,
        input logic [15:0] mask);
        int n;
        rnd = lfsr(rnd);
        rd_q.push_back({mask, rnd[31:16] & mask});
        @(posedge MCLK);
        if (!dma && !a[16]) begin
            bus_q.push_back({!WIDE_MODE, !rd, SHARED_BASE + (32'(a[15:0]) << WIDE_MODE)});
        end
        {REG_READ_DATA, FIFO_READ_DATA, BUS_READ_DATA} <= {3{rnd[31:16]}};
        {go, go_dma, go_rd, go_addr, go_data} <= {1'b1, dma, rd, a, rnd[15:0]};
        @(posedge MCLK);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 500) begin
            @(posedge MCLK);
            n++;
        end
        repeat (2) @(posedge MCLK);
        #1 cmp(TRANSCEIVER_ENABLE_N, 1, "enable released");
        cmp(acked, 0, "ack idle");
    endtask

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            give_verdict();
        end
        if (acked === 1'b1) begin
            cmp(TRANSCEIVER_ENABLE_N, 0, "xcvr enable");
            cmp(TRANSCEIVER_DIRECTION_O, go_rd, "xcvr direction");
        end
        if (done === 1'b1) begin
            e = rd_q.pop_front();
            cmp(rdata & e[31:16], e[15:0], "read data");
        end
        if (REG_READ === 1'b1) cmp(REG_INDEX, go_addr[2:0], "reg index");
        if (REG_WRITE === 1'b1) cmp(REG_WRITE_DATA[7:0], go_data[7:0], "reg write");
        if (FIFO_WRITE === 1'b1) cmp(FIFO_WRITE_DATA, go_data, "fifo data");
        if (FIFO_READ === 1'b1 || FIFO_WRITE === 1'b1) begin
            pulses++;
            cmp(FIFO_READ, go_rd, "fifo direction");
        end
    end

    // System bus side: random grant delay, then completion
    initial begin
        BUS_GRANT = 1'b0;
        BUS_DONE = 1'b0;
        forever begin
            @(posedge MCLK);
            if (BUS_REQUEST === 1'b1) begin
                repeat (rnd[1:0]) @(posedge MCLK);
                BUS_GRANT <= 1'b1;
                repeat (2) @(posedge MCLK);
                e2 = bus_q.size() ? bus_q.pop_front() : 34'h3ffffffff;
                cmp({BUS_BYTE_MODE, BUS_WRITE, BUS_ADDRESS}, e2, "bus access");
                if (BUS_WRITE === 1'b1)
                    cmp(BUS_WRITE_DATA, WIDE_MODE ? go_data : go_data[15:8], "bus data");
                {BUS_DONE, BUS_GRANT} <= 2'b10;
                @(posedge MCLK);
                BUS_DONE <= 1'b0;
                repeat (2) @(posedge MCLK);
            end
        end
    end

    initial begin
        {NRST, go, go_dma, go_rd, irq2_drv, EXTERNAL_IRQ_CLEAR, CTRL_WRITE} = 7'h00;
        {CTRL_ACK_POLARITY, CTRL_ACK_DRIVE, CTRL_IRQ_DIRECTION_N} = 3'b101;
        {STRAP_A1, STRAP_A6, STRAP_A5, ACK_SYNC_MODE, WIDE_MODE} = 5'b01001;
        {DMA_ENABLE_N, ALTERNATE_REQUEST_ROUTE, OUTBOUND_READY_ENABLE, INBOUND_ROOM_ENABLE} = 4'h8;
        {OUTBOUND_FIFO_EMPTY, INBOUND_FIFO_FULL, STATUS_IRQ_FLAG, DATA_AVAIL_IRQ_FLAG} = 4'h0;
        {FIFO_IRQ_CONDITION, GLOBAL_IRQ_ENABLE, IRQ_PIN_SELECT} = 3'h0;
        {go_addr, go_data, REG_READ_DATA, FIFO_READ_DATA, BUS_READ_DATA} = '0;
        SHARED_BASE = 32'h0012_3400;
        rnd = 32'hed9d;
        repeat (6) @(posedge MCLK);
        NRST <= 1'b1;
        repeat (2) @(posedge MCLK);
        #1 cmp({ACK_POLARITY_SELECT, ACK_DRIVE_TYPE, IRQ_PIN_DIRECTION_N}, 3'b010, "straps");
        cmp({HOST_IRQ_SECOND_OE, TRANSCEIVER_DIRECTION_OE}, 2'b01, "pin roles");
        irq2_drv <= 1'b1;
        repeat (3) @(posedge MCLK);
        #1 cmp({EXTERNAL_IRQ_FLAG, LOCAL_IRQ}, 2'b11, "external irq");
        host_cycle(1'b0, 1'b1, 17'h10003, 16'h00ff);
        @(posedge MCLK);
        {EXTERNAL_IRQ_CLEAR, CTRL_WRITE} <= 2'b11;
        @(posedge MCLK);
        {EXTERNAL_IRQ_CLEAR, CTRL_WRITE} <= 2'b00;
        repeat (2) @(posedge MCLK);
        #1 cmp({ACK_POLARITY_SELECT, ACK_DRIVE_TYPE, EXTERNAL_IRQ_FLAG}, 3'b100, "control");
        ACK_SYNC_MODE <= 1'b1;
        host_cycle(1'b0, 1'b0, 17'h10005, 16'h0000);
        ACK_SYNC_MODE <= 1'b0;
        host_cycle(1'b0, 1'b1, {1'b0, rnd[15:0]}, 16'hffff);
        host_cycle(1'b0, 1'b0, {1'b0, rnd[31:16]}, 16'h0000);
        WIDE_MODE <= 1'b0;
        host_cycle(1'b0, 1'b0, {1'b0, rnd[15:0]}, 16'h0000);
        cmp(GENERAL_INPUTS, {~go_data[7:0]}, "general inputs");
        WIDE_MODE <= 1'b1;
        DMA_ENABLE_N <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            @(posedge MCLK);
            {ALTERNATE_REQUEST_ROUTE, OUTBOUND_READY_ENABLE, INBOUND_ROOM_ENABLE,
                OUTBOUND_FIFO_EMPTY, INBOUND_FIFO_FULL} <= i[4:0];
            #1 ro = i[3] & !i[1];
            ri = i[2] & !i[0];
            if (i[4]) cmp({HOST_IRQ_SECOND_OE, HOST_IRQ_SECOND_O}, {1'b1, ro | ri}, "alt");
            else cmp({DMA_REQUEST_PIN_OE, DMA_REQUEST_PIN_O}, {2'b11, !ro, !ri}, "req");
        end
        {ALTERNATE_REQUEST_ROUTE, OUTBOUND_READY_ENABLE, INBOUND_ROOM_ENABLE} <= 3'b011;
        {OUTBOUND_FIFO_EMPTY, INBOUND_FIFO_FULL} <= 2'b00;
        host_cycle(1'b1, 1'b0, {1'b0, rnd[15:0]}, 16'h0000);
        host_cycle(1'b1, 1'b1, {1'b1, rnd[31:16]}, 16'hffff);
        cmp(pulses, 2, "fifo pulses");
        DMA_ENABLE_N <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(posedge MCLK);
            {STATUS_IRQ_FLAG, DATA_AVAIL_IRQ_FLAG, FIFO_IRQ_CONDITION, GLOBAL_IRQ_ENABLE,
                IRQ_PIN_SELECT} <= i[4:0];
            #1 ro = (i[4] | i[3] | i[2]) & i[1];
            cmp({HOST_IRQ_FIRST_N, HOST_IRQ_SECOND_O, HOST_IRQ_SECOND_OE},
                {!(ro & !i[0]), !(ro & i[0]), 1'b1}, "irq pins");
        end
        give_verdict();
    end
endmodule
